// *** rtl/amr_pkg.sv ***
// constants for the record-path configuration register slice
package amr_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] LINE_ONE_TO_RIGHT_OFS = 8'h18;
	localparam logic [7:0] MIC_BIAS_OFS = 8'h19;
	localparam logic [7:0] AGC_A_OFS = 8'h1a;
	localparam logic [7:0] AGC_B_OFS = 8'h1b;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int DIFF_POS = 7;
	localparam int LEVEL_LSB = 3;
	localparam int BIAS_LSB = 6;
	localparam int DMIC_LSB = 4;
	localparam int AGC_EN_POS = 7;
	localparam int TARGET_LSB = 4;
	localparam int ATTACK_LSB = 2;
	localparam int DECAY_LSB = 0;
	localparam int MAXGAIN_LSB = 1;
	// ----------------------------------------------------------------
	// reset values and codes
	// ----------------------------------------------------------------
	localparam logic [7:0] LINE_ONE_RST = 8'h78;
	localparam logic [7:0] MIC_BIAS_RST = 8'h00;
	localparam logic [7:0] AGC_A_RST = 8'h00;
	localparam logic [7:0] AGC_B_RST = 8'hfe;
	localparam logic [3:0] LEVEL_LAST_GAIN = 4'h8;
	localparam logic [3:0] LEVEL_OFF = 4'hf;
	localparam logic [6:0] MAXGAIN_CAP = 7'h77;
	localparam logic [7:0] LINE_ONE_WMASK = 8'hf8;
	localparam logic [7:0] MIC_BIAS_WMASK = 8'hf0;
	localparam logic [7:0] AGC_B_WMASK = 8'hfe;
	// ----------------------------------------------------------------
	// time constants in microseconds, normal rate
	// ----------------------------------------------------------------
	localparam int ATTACK_US [4] = '{8000, 11000, 16000, 20000};
	localparam int DECAY_US [4] = '{100000, 200000, 400000, 500000};
	// ----------------------------------------------------------------
	// encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		AMR_BIAS_OFF = 2'h0,
		AMR_BIAS_2V0 = 2'h1,
		AMR_BIAS_2V5 = 2'h2,
		AMR_BIAS_SUPPLY = 2'h3
	} amr_bias_t;
endpackage

// *** rtl/amr_decode.sv ***
// decodes the stored fields into analog control codes
`timescale 1ns/1ps
module amr_decode
	import amr_pkg::*;
(
	// raw fields
	input wire logic [3:0] level_code,
	input wire logic [1:0] dmic_sel,
	input wire logic [1:0] attack_code,
	input wire logic [1:0] decay_code,
	input wire logic double_rate_audio,
	input wire logic [6:0] maxgain_code,
	// decoded
	output logic line_connect,
	output logic [3:0] line_atten,
	output logic dmic_left,
	output logic dmic_right,
	output logic [31:0] attack_us,
	output logic [31:0] decay_us,
	output logic [6:0] maxgain_half_db
);
	// ----------------------------------------------------------------
	// combinational decode
	// ----------------------------------------------------------------
	// left and right digital microphone use per select code
	always_comb begin
		// a gain code connects the input; others leave it open
		line_connect = (level_code <= LEVEL_LAST_GAIN);
		// attenuation in 1.5 dB steps, code 0 is 0 dB
		line_atten = line_connect ? level_code : LEVEL_LAST_GAIN;
		dmic_left = (dmic_sel == 2'h0) || (dmic_sel == 2'h1);
		dmic_right = (dmic_sel == 2'h0) || (dmic_sel == 2'h2);
		// listed times only hold at normal rate; halved when doubled
		attack_us = double_rate_audio ? (ATTACK_US[attack_code] / 2)
			: ATTACK_US[attack_code];
		decay_us = double_rate_audio ? (DECAY_US[decay_code] / 2)
			: DECAY_US[decay_code];
		// codes at or above the cap all mean 59.5 dB
		maxgain_half_db = (maxgain_code >= MAXGAIN_CAP) ? MAXGAIN_CAP
			: maxgain_code;
	end
endmodule

// *** rtl/amr_regs.sv ***
// register slice: line routing, mic bias and left automatic gain control
`timescale 1ns/1ps
// Summary of operation
// - top bit selects differential line input
// - level codes 0..8 give 0 to -12 dB
// - gain code connects, code 1111 disconnects
// - low three bits read-only, write zero
// - bias field: off, 2.0V, 2.5V, supply
// - digital mic select per channel
// - top bit enables left gain control
// - three-bit target level -5.5 to -24 dB
// - attack 8, 11, 16, 20 ms
// - decay 100, 200, 400, 500 ms
// - listed times valid at normal rate only
// - max gain 0.5 dB steps, capped 59.5
module amr_regs
	import amr_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control bus register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// rate mode from elsewhere in the chip
	input wire logic double_rate_audio,
	// line input routing
	output logic left_line_input_one_diff,
	output logic left_line_input_one_connect,
	output logic [3:0] left_line_input_one_atten,
	// microphone bias and digital mics
	output logic [1:0] microphone_bias_output,
	output logic dmic_left,
	output logic dmic_right,
	// left gain control
	output logic agc_enable,
	output logic [2:0] agc_target,
	output logic [31:0] agc_attack_us,
	output logic [31:0] agc_decay_us,
	output logic [6:0] agc_max_half_db
);
	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [7:0] line_reg, line_next; // line one to right mix
	logic [7:0] bias_reg, bias_next; // bias and digital mic
	logic [7:0] agca_reg, agca_next; // gain control a
	logic [7:0] agcb_reg, agcb_next; // gain control b
	logic [7:0] rdata_reg, rdata_next; // read data
	logic conn_w, dl_w, dr_w; // decoded levels
	logic [3:0] att_w;
	logic [31:0] atk_w, dcy_w;
	logic [6:0] mg_w;
	logic conn_reg, dl_reg, dr_reg;
	logic [3:0] att_reg;
	logic [31:0] atk_reg, dcy_reg;
	logic [6:0] mg_reg;

	// ----------------------------------------------------------------
	// write and read next values
	// ----------------------------------------------------------------
	// writes merge through masks so reserved bits stay zero
	always_comb begin
		line_next = line_reg;
		bias_next = bias_reg;
		agca_next = agca_reg;
		agcb_next = agcb_reg;
		rdata_next = rdata_reg;
		if (reg_wr) begin
			case (reg_addr)
				LINE_ONE_TO_RIGHT_OFS: begin
					line_next = reg_wdata & LINE_ONE_WMASK;
				end
				MIC_BIAS_OFS: begin
					bias_next = reg_wdata & MIC_BIAS_WMASK;
				end
				AGC_A_OFS: begin
					agca_next = reg_wdata;
				end
				AGC_B_OFS: begin
					agcb_next = reg_wdata & AGC_B_WMASK;
				end
				default: begin
					line_next = line_reg;
				end
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				LINE_ONE_TO_RIGHT_OFS: rdata_next = line_reg;
				MIC_BIAS_OFS: rdata_next = bias_reg;
				AGC_A_OFS: rdata_next = agca_reg;
				AGC_B_OFS: rdata_next = agcb_reg;
				// unmapped offsets read as zero
				default: rdata_next = 8'h00;
			endcase
		end
	end

	// register stage for storage and read data
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			line_reg <= LINE_ONE_RST;
			bias_reg <= MIC_BIAS_RST;
			agca_reg <= AGC_A_RST;
			agcb_reg <= AGC_B_RST;
			rdata_reg <= 8'h00;
		end else begin
			line_reg <= line_next;
			bias_reg <= bias_next;
			agca_reg <= agca_next;
			agcb_reg <= agcb_next;
			rdata_reg <= rdata_next;
		end
	end

	// ----------------------------------------------------------------
	// field decode
	// ----------------------------------------------------------------
	amr_decode amr_decode_inst (
		.level_code(line_reg[LEVEL_LSB +: 4]),
		.dmic_sel(bias_reg[DMIC_LSB +: 2]),
		.attack_code(agca_reg[ATTACK_LSB +: 2]),
		.decay_code(agca_reg[DECAY_LSB +: 2]),
		.double_rate_audio(double_rate_audio),
		.maxgain_code(agcb_reg[MAXGAIN_LSB +: 7]),
		.line_connect(conn_w),
		.line_atten(att_w),
		.dmic_left(dl_w),
		.dmic_right(dr_w),
		.attack_us(atk_w),
		.decay_us(dcy_w),
		.maxgain_half_db(mg_w)
	);

	// decoded controls are registered so outputs come from flops
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			conn_reg <= 1'b0;
			att_reg <= LEVEL_LAST_GAIN;
			dl_reg <= 1'b1;
			dr_reg <= 1'b1;
			atk_reg <= 32'h0;
			dcy_reg <= 32'h0;
			mg_reg <= MAXGAIN_CAP;
		end else begin
			conn_reg <= conn_w;
			att_reg <= att_w;
			dl_reg <= dl_w;
			dr_reg <= dr_w;
			atk_reg <= atk_w;
			dcy_reg <= dcy_w;
			mg_reg <= mg_w;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign reg_rdata = rdata_reg;
	assign left_line_input_one_diff = line_reg[DIFF_POS];
	assign left_line_input_one_connect = conn_reg;
	assign left_line_input_one_atten = att_reg;
	assign microphone_bias_output = bias_reg[BIAS_LSB +: 2];
	assign dmic_left = dl_reg;
	assign dmic_right = dr_reg;
	assign agc_enable = agca_reg[AGC_EN_POS];
	assign agc_target = agca_reg[TARGET_LSB +: 3];
	assign agc_attack_us = atk_reg;
	assign agc_decay_us = dcy_reg;
	assign agc_max_half_db = mg_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_line_wr;
		reg_wr && reg_addr == LINE_ONE_TO_RIGHT_OFS;
	endsequence
	a_diff_follows_wr: assert property (@(posedge clk) disable iff (rst)
		s_line_wr |=> left_line_input_one_diff == $past(reg_wdata[7]))
		else $error("differential bit did not follow write");
	a_reserved_line_zero: assert property (@(posedge clk) disable iff (rst)
		line_reg[2:0] == 3'h0)
		else $error("reserved line bits not zero");
	a_bias_low_zero: assert property (@(posedge clk) disable iff (rst)
		bias_reg[3:0] == 4'h0)
		else $error("reserved bias bits not zero");
	a_connect_on_gain: assert property (@(posedge clk) disable iff (rst)
		s_line_wr ##1 !reg_wr[*2] |->
		left_line_input_one_connect == (line_reg[6:3] <= 4'h8))
		else $error("connect does not match level code");
	a_atten_value: assert property (@(posedge clk) disable iff (rst)
		$stable(line_reg) && line_reg[6:3] <= 4'h8 |=>
		left_line_input_one_atten == $past(line_reg[6:3]))
		else $error("attenuation code mismatch");
	a_bias_level: assert property (@(posedge clk) disable iff (rst)
		reg_wr && reg_addr == MIC_BIAS_OFS |=>
		microphone_bias_output == $past(reg_wdata[7:6]))
		else $error("bias level not applied");
	a_dmic_both: assert property (@(posedge clk) disable iff (rst)
		bias_reg[5:4] == 2'h0 && $stable(bias_reg) |=>
		dmic_left && dmic_right)
		else $error("both digital mics expected");
	a_agc_enable: assert property (@(posedge clk) disable iff (rst)
		reg_wr && reg_addr == AGC_A_OFS |=>
		agc_enable == $past(reg_wdata[7]) &&
		agc_target == $past(reg_wdata[6:4]))
		else $error("gain control a not applied");
	a_maxgain_cap: assert property (@(posedge clk) disable iff (rst)
		##1 agc_max_half_db <= 7'h77)
		else $error("max gain above cap");
	a_attack_rate: assert property (@(posedge clk) disable iff (rst)
		!double_rate_audio && agca_reg[3:2] == 2'h0 && $stable(agca_reg)
		|=> agc_attack_us == 32'd8000)
		else $error("attack time mismatch");
	a_read_back: assert property (@(posedge clk) disable iff (rst)
		reg_rd && reg_addr == AGC_B_OFS |=> reg_rdata == $past(agcb_reg))
		else $error("read data mismatch");
endmodule

// *** tb/amr_regs_bench.sv ***
// self-checking bench for the record-path configuration register slice
`timescale 1ns/1ps
module amr_regs_bench;
	// ------------------------------------------------------------
	// stimulus and observed signals
	// ------------------------------------------------------------
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic double_rate_audio = 1'b0;
	logic diff, conn, dl, dr, en;
	logic [3:0] atten;
	logic [1:0] bias;
	logic [2:0] tgt;
	logic [31:0] att_us, dec_us;
	logic [6:0] maxg;
	int num_errors = 0;
	int checks = 0;
	// expected time constants at normal rate, in microseconds
	int att_tab [4] = '{8000, 11000, 16000, 20000};
	int dec_tab [4] = '{100000, 200000, 400000, 500000};
	// gain caps around zero and around the saturation point
	logic [6:0] mg_tab [6] = '{7'h00, 7'h01, 7'h76, 7'h77, 7'h78, 7'h7f};
	// 25 MHz clock
	always #20 clk = ~clk;
	amr_regs amr_regs_inst (
		.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.double_rate_audio(double_rate_audio),
		.left_line_input_one_diff(diff),
		.left_line_input_one_connect(conn),
		.left_line_input_one_atten(atten),
		.microphone_bias_output(bias), .dmic_left(dl), .dmic_right(dr),
		.agc_enable(en), .agc_target(tgt), .agc_attack_us(att_us),
		.agc_decay_us(dec_us), .agc_max_half_db(maxg)
	);
	// ------------------------------------------------------------
	// access and compare tasks
	// ------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one-cycle write strobe, then let decoded outputs settle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	// one-cycle read strobe, data valid after the taking edge
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check("reg_rdata", {24'h0, reg_rdata}, {24'h0, exp});
	endtask
	// reset values of every register and of the decoded outputs
	task automatic rd_rst();
		check("connect", conn, 0);
		check("atten", atten, 8);
		check("dmic", {dl, dr}, 2'h3);
		check("maxgain", maxg, 7'h77);
		check("attack", att_us, 8000);
		check("decay", dec_us, 100000);
		rd(8'h18, 8'h78);
		rd(8'h19, 8'h00);
		rd(8'h1a, 8'h00);
		rd(8'h1b, 8'hfe);
		rd(8'h1c, 8'h00);
	endtask
	task automatic conclude();
		if (num_errors == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		rd_rst();
		// reserved low bits written as zero, code 1111 leaves input off
		wr(8'h18, 8'hf8);
		rd(8'h18, 8'hf8);
		check("diff", diff, 1);
		check("connect", conn, 0);
		for (int i = 0; i <= 8; i++) begin
			wr(8'h18, {1'b0, i[3:0], 3'h0});
			check("diff", diff, 0);
			check("connect", conn, 1);
			check("atten", atten, i);
			rd(8'h18, {1'b0, i[3:0], 3'h0});
		end
		// every bias level with every legal mic selection
		for (int b = 0; b < 4; b++) begin
			for (int d = 0; d < 3; d++) begin
				wr(8'h19, {b[1:0], d[1:0], 4'h0});
				check("bias", bias, b);
				check("dmic", {dl, dr}, (d == 0) ? 3 : 3 - d);
				rd(8'h19, {b[1:0], d[1:0], 4'h0});
			end
		end
		wr(8'h19, 8'h00);
		rd(8'h19, 8'h00);
		// enable, target, attack and decay codes
		for (int i = 0; i < 16; i++) begin
			wr(8'h1a, {i[3], i[2:0], i[3:2], i[1:0]});
			check("enable", en, i[3]);
			check("target", tgt, i[2:0]);
			check("attack", att_us, att_tab[i[3:2]]);
			check("decay", dec_us, dec_tab[i[1:0]]);
			rd(8'h1a, {i[3], i[2:0], i[3:2], i[1:0]});
		end
		// double rate mode changes the time constants
		@(posedge clk);
		double_rate_audio <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		check("attack", att_us, att_tab[3] / 2);
		check("decay", dec_us, dec_tab[3] / 2);
		// gain cap saturates at 59.5 dB
		foreach (mg_tab[k]) begin
			wr(8'h1b, {mg_tab[k], 1'b0});
			check("maxgain", maxg, (mg_tab[k] > 7'h77) ? 7'h77 : mg_tab[k]);
			rd(8'h1b, {mg_tab[k], 1'b0});
		end
		wr(8'h1b, 8'h00);
		rd(8'h1b, 8'h00);
		// unmapped write leaves neighbours alone
		wr(8'h1c, 8'h55);
		rd(8'h1b, 8'h00);
		rd(8'h1c, 8'h00);
		// second reset in mid-run restores everything
		@(posedge clk);
		rst <= 1'b1;
		double_rate_audio <= 1'b0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		rd_rst();
		conclude();
	end
	// watchdog against a hung run
	initial begin
		#400000;
		num_errors++;
		conclude();
	end
endmodule
